// file: inc/cir_consts.svh
`ifndef CIR_CONSTS_SVH
`define CIR_CONSTS_SVH

// program start address loaded by reset
`define CIR_PC_START 16'hFFFC
// width of the program counter
`define CIR_PC_W 16
// number of peripheral interrupt sources
`define CIR_NSRC 4
// stack pointer value after reset
`define CIR_SP_INIT 8'hFF
// stack page high byte
`define CIR_STACK_HI 8'h01
// vector locations for the service address
`define CIR_VEC_IRQ 16'hFFFE
`define CIR_VEC_NMI 16'hFFFA

`endif

// file: inc/cir_if.sv
`timescale 1ns/1ps
`default_nettype none

// wired-or request lines between processor and peripheral interface devices
interface cir_if;
    logic irq_req_n;
    logic nmi_req_n;
    logic rst_n;
    logic svc_ack;
    modport cpu (input irq_req_n, input nmi_req_n, output rst_n, output svc_ack);
    modport periph (output irq_req_n, output nmi_req_n, input rst_n, input svc_ack);
endinterface : cir_if

`default_nettype wire

// file: inc/cir_pkg.sv
`include "cir_consts.svh"

package cir_pkg;
    // sequencer states of the processor end
    typedef enum logic [2:0] {
        CIR_RUN,
        CIR_PUSH_HI,
        CIR_PUSH_LO,
        CIR_PUSH_ST,
        CIR_VEC_LO,
        CIR_VEC_HI
    } cir_state_e;
    typedef logic [`CIR_PC_W-1:0] cir_addr_t;
endpackage : cir_pkg

// file: logic/cir_cpu_end.sv
// Summary of operation
// - low request with inhibit clear is taken
// - taking an interrupt sets the inhibit flag
// - clear-flag instruction clears inhibit, return instruction loads it from rti_flag
// - software clears inhibit only after request removed
// - each falling request edge gives one interrupt
// - held-low line gives no further interrupts
// - non-maskable request ignores the inhibit flag
// - interrupts taken only at instruction boundary
// - enabled programmed edge drives request low
// - peripheral latch holds request until serviced
// - only service software or processor reset clears peripheral latch
// - reset held low until supplies stable
// - reset loads program counter with program start
// - reset disables peripheral interrupt sources
// - push counter and status, fetch vector
`timescale 1ns/1ps
`default_nettype none
`include "cir_consts.svh"

module cir_cpu_end (
    // clock, reset, enable
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // link to peripherals
    cir_if.cpu link,
    // instruction sequencer
    input wire logic instr_done,
    input wire logic cli_exec,
    input wire logic sei_exec,
    input wire logic rti_exec,
    input wire logic rti_flag,
    input wire logic svc_clear,
    input wire logic [7:0] mem_rdata,
    // memory and status view
    output logic [`CIR_PC_W-1:0] mem_addr,
    output logic [7:0] mem_wdata,
    output logic mem_we,
    output logic [`CIR_PC_W-1:0] pc,
    output logic inhibit,
    output logic in_service,
    output logic nmi_taken
);
    import cir_pkg::*;

    cir_state_e state_reg, state_next;
    logic irq_s1_reg, irq_s2_reg, nmi_s1_reg, nmi_s2_reg, nmi_s3_reg;
    logic nmi_pend_reg, nmi_pend_next;
    logic is_nmi_reg, is_nmi_next;
    logic inh_reg, inh_next;
    logic [15:0] pc_reg, pc_next;
    logic [7:0] sp_reg, sp_next;
    logic [15:0] addr_reg, addr_next;
    logic [7:0] wd_reg, wd_next;
    logic we_reg, we_next;
    logic svc_reg, svc_next;
    logic ack_reg, ack_next;
    logic rst_n_reg;
    logic nmi_fall;
    logic irq_take;

    // two-stage synchronisers; the first stage feeds only the second
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_s1_reg <= 1'h1;
            irq_s2_reg <= 1'h1;
            nmi_s1_reg <= 1'h1;
            nmi_s2_reg <= 1'h1;
            nmi_s3_reg <= 1'h1;
        end else if (clk_en) begin
            irq_s1_reg <= link.irq_req_n;
            irq_s2_reg <= irq_s1_reg;
            nmi_s1_reg <= link.nmi_req_n;
            nmi_s2_reg <= nmi_s1_reg;
            nmi_s3_reg <= nmi_s2_reg;
        end
    end

    // edge from successive registered samples, so a held-low line re-arms only via high
    assign nmi_fall = nmi_s3_reg & ~nmi_s2_reg;
    // level request, masked by inhibit, only at instruction boundary
    assign irq_take = ~irq_s2_reg & ~inh_reg & instr_done;

    // sequencer next state
    always_comb begin
        state_next = state_reg;
        nmi_pend_next = nmi_pend_reg;
        is_nmi_next = is_nmi_reg;
        inh_next = inh_reg;
        pc_next = pc_reg;
        sp_next = sp_reg;
        addr_next = addr_reg;
        wd_next = wd_reg;
        we_next = 1'h0;
        svc_next = svc_reg;
        ack_next = svc_clear;
        // pending edge is taken regardless of inhibit
        if (nmi_fall) begin
            nmi_pend_next = 1'h1;
        end
        case (state_reg)
            CIR_RUN: begin
                if (cli_exec) begin
                    inh_next = 1'h0;
                end
                if (sei_exec) begin
                    inh_next = 1'h1;
                end
                if (rti_exec) begin
                    inh_next = rti_flag;
                    svc_next = 1'h0;
                end
                if (instr_done && (nmi_pend_reg || nmi_fall)) begin
                    is_nmi_next = 1'h1;
                    nmi_pend_next = 1'h0;
                    state_next = CIR_PUSH_HI;
                end else if (irq_take) begin
                    is_nmi_next = 1'h0;
                    state_next = CIR_PUSH_HI;
                end
                if (state_next == CIR_PUSH_HI) begin
                    addr_next = {`CIR_STACK_HI, sp_reg};
                    wd_next = pc_reg[15:8];
                    we_next = 1'h1;
                    sp_next = sp_reg - 8'h01;
                end
            end
            CIR_PUSH_HI: begin
                addr_next = {`CIR_STACK_HI, sp_reg};
                wd_next = pc_reg[7:0];
                we_next = 1'h1;
                sp_next = sp_reg - 8'h01;
                state_next = CIR_PUSH_LO;
            end
            CIR_PUSH_LO: begin
                addr_next = {`CIR_STACK_HI, sp_reg};
                wd_next = {5'h00, inh_reg, 2'h0};
                we_next = 1'h1;
                sp_next = sp_reg - 8'h01;
                inh_next = 1'h1;
                state_next = CIR_PUSH_ST;
            end
            CIR_PUSH_ST: begin
                addr_next = is_nmi_reg ? `CIR_VEC_NMI : `CIR_VEC_IRQ;
                state_next = CIR_VEC_LO;
            end
            CIR_VEC_LO: begin
                pc_next = {pc_reg[15:8], mem_rdata};
                addr_next = addr_reg + 16'h0001;
                state_next = CIR_VEC_HI;
            end
            CIR_VEC_HI: begin
                pc_next = {mem_rdata, pc_reg[7:0]};
                svc_next = 1'h1;
                state_next = CIR_RUN;
            end
            default: begin
                state_next = CIR_RUN;
            end
        endcase
    end

    // registers; reset defines the program counter, stack pointer, inhibit flag and peripheral reset, the rest is tidy-up only
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= CIR_RUN;
            pc_reg <= `CIR_PC_START;
            sp_reg <= `CIR_SP_INIT;
            inh_reg <= 1'h1;
            nmi_pend_reg <= 1'h0;
            is_nmi_reg <= 1'h0;
            addr_reg <= `CIR_PC_START;
            wd_reg <= 8'h00;
            we_reg <= 1'h0;
            svc_reg <= 1'h0;
            ack_reg <= 1'h0;
            rst_n_reg <= 1'h0;
        end else if (clk_en) begin
            state_reg <= state_next;
            pc_reg <= pc_next;
            sp_reg <= sp_next;
            inh_reg <= inh_next;
            nmi_pend_reg <= nmi_pend_next;
            is_nmi_reg <= is_nmi_next;
            addr_reg <= addr_next;
            wd_reg <= wd_next;
            we_reg <= we_next;
            svc_reg <= svc_next;
            ack_reg <= ack_next;
            rst_n_reg <= 1'h1;
        end
    end

    assign link.rst_n = rst_n_reg;
    assign link.svc_ack = ack_reg;
    assign mem_addr = addr_reg;
    assign mem_wdata = wd_reg;
    assign mem_we = we_reg;
    assign pc = pc_reg;
    assign inhibit = inh_reg;
    assign in_service = svc_reg;
    assign nmi_taken = is_nmi_reg;
endmodule : cir_cpu_end

`default_nettype wire

// file: logic/cir_periph_end.sv
`timescale 1ns/1ps
`default_nettype none
`include "cir_consts.svh"

module cir_periph_end (
    // clock, enable
    input wire logic clk,
    input wire logic clk_en,
    // link to processor
    cir_if.periph link,
    // peripheral side
    input wire logic [`CIR_NSRC-1:0] src_in,
    input wire logic [`CIR_NSRC-1:0] edge_rise,
    input wire logic [`CIR_NSRC-1:0] en_wr,
    input wire logic [`CIR_NSRC-1:0] en_data,
    input wire logic [`CIR_NSRC-1:0] nmi_route,
    output logic [`CIR_NSRC-1:0] flags
);
    import cir_pkg::*;

    logic [`CIR_NSRC-1:0] prev_reg, prev_next, flag_reg, flag_next, en_reg, en_next;
    logic irq_n_reg, irq_n_next, nmi_n_reg, nmi_n_next;
    logic [`CIR_NSRC-1:0] hit;

    // programmed edge detect, gated by enable
    always_comb begin
        hit = (edge_rise & src_in & ~prev_reg) | (~edge_rise & ~src_in & prev_reg);
        prev_next = src_in;
        en_next = en_reg;
        for (int i = 0; i < `CIR_NSRC; i++) begin
            if (en_wr[i]) begin
                en_next[i] = en_data[i];
            end
        end
        // set wins over the service clear
        flag_next = (link.svc_ack ? '0 : flag_reg) | (hit & en_reg);
        irq_n_next = ~|(flag_next & ~nmi_route);
        nmi_n_next = ~|(flag_next & nmi_route);
    end

    // processor reset forces enables to the disabled state; only en_wr writes enable them again
    always_ff @(posedge clk) begin
        if (!link.rst_n) begin
            prev_reg <= '0;
            flag_reg <= '0;
            en_reg <= '0;
            irq_n_reg <= 1'h1;
            nmi_n_reg <= 1'h1;
        end else if (clk_en) begin
            prev_reg <= prev_next;
            flag_reg <= flag_next;
            en_reg <= en_next;
            irq_n_reg <= irq_n_next;
            nmi_n_reg <= nmi_n_next;
        end
    end

    assign link.irq_req_n = irq_n_reg;
    assign link.nmi_req_n = nmi_n_reg;
    assign flags = flag_reg;
endmodule : cir_periph_end

`default_nettype wire

// file: tb/cir_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "cir_consts.svh"

module cir_checker (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // request link
    input wire logic irq_req_n,
    input wire logic nmi_req_n,
    input wire logic rst_n,
    input wire logic svc_ack,
    // processor view
    input wire logic instr_done,
    input wire logic mem_we,
    input wire logic [`CIR_PC_W-1:0] mem_addr,
    input wire logic [`CIR_PC_W-1:0] pc,
    input wire logic inhibit,
    input wire logic in_service,
    input wire logic [`CIR_NSRC-1:0] flags
);
    logic mem_we_reg, mem_we_next;
    logic [1:0] nmi_cnt_reg, nmi_cnt_next;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // sequence starts while the edge line stays low; saturates so it cannot wrap back
    always_comb begin
        mem_we_next = mem_we;
        nmi_cnt_next = nmi_cnt_reg;
        if (nmi_req_n || sys_rst) begin
            nmi_cnt_next = 2'h0;
        end else if (mem_we && !mem_we_reg && irq_req_n && nmi_cnt_reg != 2'h3) begin
            nmi_cnt_next = nmi_cnt_reg + 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        mem_we_reg <= mem_we_next;
        nmi_cnt_reg <= nmi_cnt_next;
    end

    rst_hold_a: assert property (disable iff (1'b0) sys_rst |=> !rst_n)
        else $error("peripheral reset not low");
    pc_start_a: assert property (disable iff (1'b0) sys_rst |=> pc == `CIR_PC_START && inhibit)
        else $error("reset state wrong");
    inhibit_set_a: assert property ($rose(inhibit) && !$past(sys_rst) |-> mem_we || $past(mem_we))
        else $error("inhibit set without push");
    irq_take_a: assert property ((!irq_req_n && !inhibit && instr_done) [*3] |-> ##[0:4] mem_we)
        else $error("level request not taken");
    boundary_a: assert property ($rose(mem_we) |-> $past(instr_done) || $past(instr_done, 2))
        else $error("taken off boundary");
    nmi_edge_a: assert property ($fell(nmi_req_n) |-> ##[1:16] mem_we)
        else $error("edge request not taken");
    nmi_once_a: assert property (nmi_cnt_reg < 2'h2)
        else $error("held edge line retaken");
    latch_hold_a: assert property (!svc_ack && rst_n |=> (flags & $past(flags)) == $past(flags))
        else $error("latched flag lost");
    svc_clear_a: assert property (svc_ack |=> flags == '0)
        else $error("flags not cleared");
    vector_a: assert property ($rose(in_service) |-> $past(mem_addr) inside {`CIR_VEC_IRQ + 16'h1, `CIR_VEC_NMI + 16'h1})
        else $error("vector fetch missing");

    cover property ($rose(in_service));
    cover property ($fell(nmi_req_n));
    cover property (svc_ack);
endmodule : cir_checker

`default_nettype wire

// file: tb/cpu_interrupt_reset_logic_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "cir_consts.svh"

module cpu_interrupt_reset_logic_tb;
    logic clk = 1'b0, sys_rst = 1'b1, instr_done = 1'b1, clk_en = 1'b1;
    logic cli_exec = 1'b0, rti_exec = 1'b0, svc_clear = 1'b0, mem_we, inhibit, in_service, nmi_taken;
    logic [`CIR_NSRC-1:0] src_in = 4'h4, en_wr = 4'h0, flags;
    logic [`CIR_PC_W-1:0] mem_addr, pc;
    logic [7:0] mem_rdata;
    int bad_count = 0, cmp_count = 0, we_cnt = 0, cyc = 0;

    cir_if cir_if_i ();
    // vector bytes differ so a swapped pair shows
    assign mem_rdata = mem_addr[0] ? 8'h12 : 8'h34;
    cir_cpu_end cir_cpu_end_i (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .link(cir_if_i.cpu),
        .instr_done(instr_done), .cli_exec(cli_exec), .sei_exec(1'b0), .rti_exec(rti_exec),
        .rti_flag(1'b0), .svc_clear(svc_clear), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
        .mem_wdata(), .mem_we(mem_we), .pc(pc), .inhibit(inhibit), .in_service(in_service),
        .nmi_taken(nmi_taken));
    // source 2 falls onto the edge line, the rest rise onto the level line
    cir_periph_end cir_periph_end_i (.clk(clk), .clk_en(clk_en), .link(cir_if_i.periph), .src_in(src_in),
        .edge_rise(4'hB), .en_wr(en_wr), .en_data(en_wr), .nmi_route(4'h4), .flags(flags));
    cir_checker cir_checker_i (.clk(clk), .sys_rst(sys_rst), .irq_req_n(cir_if_i.irq_req_n),
        .nmi_req_n(cir_if_i.nmi_req_n), .rst_n(cir_if_i.rst_n), .svc_ack(cir_if_i.svc_ack),
        .instr_done(instr_done), .mem_we(mem_we), .mem_addr(mem_addr), .pc(pc), .inhibit(inhibit),
        .in_service(in_service), .flags(flags));

    initial begin
        forever #12.5 clk = ~clk;
    end

    // write counter; a hang is cut short after 2000 cycles
    always @(posedge clk) begin
        cyc++;
        if (mem_we === 1'b1) we_cnt++;
        if (cyc == 2000) begin
            bad_count++;
            end_sim();
        end
    end

    task end_sim();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_sim

    task tick(int n);
        repeat (n) @(negedge clk);
    endtask : tick

    task chk(logic [15:0] got, logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    // three pushes per taken interrupt, so writes count the takes
    task takes(int n, int exp);
        int b;
        b = we_cnt;
        tick(n);
        chk(16'(we_cnt - b), 16'(exp));
    endtask : takes

    task strobe(int which);
        if (which == 0) cli_exec = 1'b1;
        else if (which == 1) rti_exec = 1'b1;
        else svc_clear = 1'b1;
        tick(1);
        {cli_exec, rti_exec, svc_clear} = 3'h0;
        // a take started by cli or rti must fall inside the caller's count window;
        // a clear waits for the raised level line to pass both sync stages
        tick(which == 2 ? 3 : 1);
    endtask : strobe

    initial begin
        tick(10);
        chk(pc, `CIR_PC_START);
        chk(16'(cir_if_i.rst_n), 16'h0);
        sys_rst = 1'b0;
        tick(2);
        en_wr = 4'hF;
        tick(1);
        en_wr = 4'h0;
        $display("reset test done");
        src_in[0] = 1'b1;
        takes(20, 0);
        chk(16'(cir_if_i.irq_req_n), 16'h0);
        strobe(0);
        takes(20, 3);
        chk(16'(inhibit), 16'h1);
        chk(pc, 16'h1234);
        chk(16'(flags), 16'h1);
        strobe(1);
        takes(20, 3);
        strobe(2);
        chk(16'(flags), 16'h0);
        strobe(0);
        chk(16'(inhibit), 16'h0);
        takes(20, 0);
        $display("level request test done");
        instr_done = 1'b0;
        // frozen ends must not see the new source edge until enabled again
        clk_en = 1'b0;
        src_in[1] = 1'b1;
        takes(20, 0);
        chk(16'(flags), 16'h0);
        clk_en = 1'b1;
        takes(20, 0);
        chk(16'(flags), 16'h2);
        instr_done = 1'b1;
        takes(20, 3);
        strobe(2);
        $display("boundary test done");
        src_in[2] = 1'b0;
        takes(20, 3);
        chk(16'(nmi_taken), 16'h1);
        takes(30, 0);
        strobe(2);
        chk(16'(cir_if_i.nmi_req_n), 16'h1);
        src_in[2] = 1'b1;
        tick(3);
        src_in[2] = 1'b0;
        takes(20, 3);
        strobe(2);
        $display("edge request test done");
        sys_rst = 1'b1;
        tick(2);
        chk(pc, `CIR_PC_START);
        sys_rst = 1'b0;
        src_in[0] = 1'b0;
        tick(3);
        src_in[0] = 1'b1;
        tick(3);
        chk(16'(flags), 16'h0);
        $display("second reset test done");
        end_sim();
    end
endmodule : cpu_interrupt_reset_logic_tb

`default_nettype wire
